// *** phyreg_regs.sv ***
// Transceiver control and 10 Mb/s status/control registers.
`timescale 1ns/10ps
`default_nettype none
module phyreg_regs (
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  // Management register access, already decoded from the serial frame.
  input  wire logic [4:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [15:0] REG_WDATA,
  output var  logic [15:0] REG_RDATA,
  output var  logic        REG_RVALID,
  // Strap pins, sampled once after reset release.
  input  wire logic        STRAP_AUTO_XOVER,
  input  wire logic [4:0]  STRAP_MGMT_ADDR,
  // Negotiation and link state from the core logic.
  input  wire logic [1:0]  LOCAL_PAUSE_ADV,
  input  wire logic [1:0]  PARTNER_PAUSE_ADV,
  input  wire logic        AN_COMPLETE,
  input  wire logic        HCD_FULL_DUPLEX,
  input  wire logic        LINK_UP,
  input  wire logic        SPEED_100,
  input  wire logic        POLARITY_INV_EVT,
  // Controls towards the core logic.
  output var  logic        AUTO_XOVER_EN,
  output var  logic        FORCE_XOVER,
  output var  logic        INDICATOR_STRETCH_BYPASS,
  output var  logic        INDICATOR_CONFIG,
  output var  logic        LOWER_RX_THRESHOLD,
  output var  logic [3:0]  SQUELCH_SEL,
  output var  logic        LINK_PULSE_TX_OFF,
  output var  logic        JABBER_OFF,
  output var  logic        PAUSE_RX_EN,
  output var  logic        PAUSE_TX_EN,
  output var  logic        AN_LINK100_FD,
  output var  logic        POLARITY_FLAG,
  output var  logic [4:0]  MGMT_ADDR
);
  // --------------------------------------------------------------------
  // Strap capture
  // --------------------------------------------------------------------
  logic [5:0] strap_s;
  logic [1:0] settle_q;
  logic       strap_take;

  phyreg_sync #(.W(6)) u_strap_sync (
    .MCLK   (MCLK),
    .RESETN (RESETN),
    .D      ({STRAP_AUTO_XOVER, STRAP_MGMT_ADDR}),
    .Q      (strap_s)
  );

  // Waits out the synchroniser so that the straps are valid when taken.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      settle_q <= 2'h0;
    end else if (settle_q != phyreg_pkg::STRAP_SETTLE_CYC) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  assign strap_take = (settle_q == phyreg_pkg::STRAP_SETTLE_CYC - 2'h1);

  // --------------------------------------------------------------------
  // Write and read decode
  // --------------------------------------------------------------------
  logic wr_xc;
  logic wr_ts;
  logic rd_ts;

  assign wr_xc = REG_WR && (REG_ADDR == phyreg_pkg::XCVR_CTRL_OFS);
  assign wr_ts = REG_WR && (REG_ADDR == phyreg_pkg::TENB_STATCTL_OFS);
  assign rd_ts = REG_RD && (REG_ADDR == phyreg_pkg::TENB_STATCTL_OFS);

  // --------------------------------------------------------------------
  // Transceiver control fields
  // --------------------------------------------------------------------
  // A write in the strap cycle wins, so software keeps its override.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      AUTO_XOVER_EN <=
        phyreg_pkg::XCVR_CTRL_RST[phyreg_pkg::XC_AUTO_XOVER_BIT];
    end else if (wr_xc) begin
      AUTO_XOVER_EN <= REG_WDATA[phyreg_pkg::XC_AUTO_XOVER_BIT];
    end else if (strap_take) begin
      AUTO_XOVER_EN <= strap_s[5];
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      MGMT_ADDR <= phyreg_pkg::XCVR_CTRL_RST[4:0];
    end else if (strap_take) begin
      MGMT_ADDR <= strap_s[4:0];
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      FORCE_XOVER <=
        phyreg_pkg::XCVR_CTRL_RST[phyreg_pkg::XC_FORCE_XOVER_BIT];
      INDICATOR_STRETCH_BYPASS <=
        phyreg_pkg::XCVR_CTRL_RST[phyreg_pkg::XC_STRETCH_BYP_BIT];
      INDICATOR_CONFIG <=
        phyreg_pkg::XCVR_CTRL_RST[phyreg_pkg::XC_IND_CONFIG_BIT];
    end else if (wr_xc) begin
      FORCE_XOVER <= REG_WDATA[phyreg_pkg::XC_FORCE_XOVER_BIT];
      INDICATOR_STRETCH_BYPASS <=
        REG_WDATA[phyreg_pkg::XC_STRETCH_BYP_BIT];
      INDICATOR_CONFIG <= REG_WDATA[phyreg_pkg::XC_IND_CONFIG_BIT];
    end
  end

  // --------------------------------------------------------------------
  // Negotiated status
  // --------------------------------------------------------------------
  logic lp;
  logic la;
  logic rp;
  logic ra;
  logic fd_hcd;

  assign lp = LOCAL_PAUSE_ADV[phyreg_pkg::ADV_PAUSE_BIT];
  assign la = LOCAL_PAUSE_ADV[phyreg_pkg::ADV_ASYM_BIT];
  assign rp = PARTNER_PAUSE_ADV[phyreg_pkg::ADV_PAUSE_BIT];
  assign ra = PARTNER_PAUSE_ADV[phyreg_pkg::ADV_ASYM_BIT];
  assign fd_hcd = AN_COMPLETE && HCD_FULL_DUPLEX;

  // Registered so a read never sees a half-settled negotiation result.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      PAUSE_RX_EN   <= 1'b0;
      PAUSE_TX_EN   <= 1'b0;
      AN_LINK100_FD <= 1'b0;
    end else begin
      PAUSE_RX_EN   <= fd_hcd
                       && ((lp && rp) || (lp && la && !rp && ra));
      PAUSE_TX_EN   <= fd_hcd
                       && ((lp && rp) || (!lp && la && rp && ra));
      AN_LINK100_FD <= AN_COMPLETE && HCD_FULL_DUPLEX && LINK_UP
                       && SPEED_100;
    end
  end

  // --------------------------------------------------------------------
  // 10 Mb/s status and control fields
  // --------------------------------------------------------------------
  logic jabber_off_q;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      LOWER_RX_THRESHOLD <=
        phyreg_pkg::TENB_STATCTL_RST[phyreg_pkg::TS_LOW_THRESH_BIT];
      SQUELCH_SEL <= phyreg_pkg::TENB_STATCTL_RST[12:9];
      LINK_PULSE_TX_OFF <=
        phyreg_pkg::TENB_STATCTL_RST[phyreg_pkg::TS_LINK_PULSE_BIT];
      jabber_off_q <=
        phyreg_pkg::TENB_STATCTL_RST[phyreg_pkg::TS_JABBER_OFF_BIT];
    end else if (wr_ts) begin
      LOWER_RX_THRESHOLD <= REG_WDATA[phyreg_pkg::TS_LOW_THRESH_BIT];
      SQUELCH_SEL <= REG_WDATA[phyreg_pkg::TS_SQUELCH_LSB +:
                               phyreg_pkg::TS_SQUELCH_W];
      LINK_PULSE_TX_OFF <= REG_WDATA[phyreg_pkg::TS_LINK_PULSE_BIT];
      jabber_off_q <= REG_WDATA[phyreg_pkg::TS_JABBER_OFF_BIT];
    end
  end

  // At 100 Mb/s the jabber function is not used, so the bit has no effect.
  assign JABBER_OFF = jabber_off_q && !SPEED_100;

  // One flag serves both the status register bit and its mirror; a new
  // event in the clearing read cycle is kept.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      POLARITY_FLAG <= 1'b0;
    end else if (POLARITY_INV_EVT) begin
      POLARITY_FLAG <= 1'b1;
    end else if (rd_ts) begin
      POLARITY_FLAG <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  logic [15:0] xc_view;
  logic [15:0] ts_view;

  always_comb begin
    xc_view = 16'h0000;
    xc_view[phyreg_pkg::XC_AUTO_XOVER_BIT]  = AUTO_XOVER_EN;
    xc_view[phyreg_pkg::XC_FORCE_XOVER_BIT] = FORCE_XOVER;
    xc_view[phyreg_pkg::XC_PAUSE_RX_BIT]    = PAUSE_RX_EN;
    xc_view[phyreg_pkg::XC_PAUSE_TX_BIT]    = PAUSE_TX_EN;
    xc_view[phyreg_pkg::XC_AN_LINK100_BIT]  = AN_LINK100_FD;
    xc_view[phyreg_pkg::XC_STRETCH_BYP_BIT] = INDICATOR_STRETCH_BYPASS;
    xc_view[phyreg_pkg::XC_IND_CONFIG_BIT]  = INDICATOR_CONFIG;
    xc_view[phyreg_pkg::XC_MGMT_ADDR_LSB +: phyreg_pkg::XC_MGMT_ADDR_W] =
      MGMT_ADDR;
  end

  always_comb begin
    ts_view = 16'h0000;
    ts_view[phyreg_pkg::TS_LOW_THRESH_BIT] = LOWER_RX_THRESHOLD;
    ts_view[phyreg_pkg::TS_SQUELCH_LSB +: phyreg_pkg::TS_SQUELCH_W] =
      SQUELCH_SEL;
    ts_view[phyreg_pkg::TS_LINK_PULSE_BIT] = LINK_PULSE_TX_OFF;
    ts_view[phyreg_pkg::TS_POLARITY_BIT]   = POLARITY_FLAG;
    ts_view[phyreg_pkg::TS_JABBER_OFF_BIT] = jabber_off_q;
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA  <= 16'h0000;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        case (REG_ADDR)
          phyreg_pkg::XCVR_CTRL_OFS:    REG_RDATA <= xc_view;
          phyreg_pkg::TENB_STATCTL_OFS: REG_RDATA <= ts_view;
          default:                      REG_RDATA <= 16'h0000;
        endcase
      end
    end
  end
endmodule : phyreg_regs
`default_nettype wire

// *** phyreg_pkg.sv ***
// Constants shared by the transceiver control and status register block.
`default_nettype none
package phyreg_pkg;
  // --------------------------------------------------------------------
  // Register offsets on the management address space
  // --------------------------------------------------------------------
  localparam logic [4:0]  XCVR_CTRL_OFS    = 5'h19;
  localparam logic [4:0]  TENB_STATCTL_OFS = 5'h1a;
  // --------------------------------------------------------------------
  // Values after reset
  // --------------------------------------------------------------------
  localparam logic [15:0] XCVR_CTRL_RST    = 16'h8000;
  localparam logic [15:0] TENB_STATCTL_RST = 16'h0000;
  // --------------------------------------------------------------------
  // Field positions of the transceiver control register
  // --------------------------------------------------------------------
  localparam int XC_AUTO_XOVER_BIT  = 15;
  localparam int XC_FORCE_XOVER_BIT = 14;
  localparam int XC_PAUSE_RX_BIT    = 13;
  localparam int XC_PAUSE_TX_BIT    = 12;
  localparam int XC_AN_LINK100_BIT  = 11;
  localparam int XC_STRETCH_BYP_BIT = 7;
  localparam int XC_IND_CONFIG_BIT  = 5;
  localparam int XC_MGMT_ADDR_LSB   = 0;
  localparam int XC_MGMT_ADDR_W     = 5;
  // --------------------------------------------------------------------
  // Field positions of the 10 Mb/s status and control register
  // --------------------------------------------------------------------
  localparam int TS_LOW_THRESH_BIT  = 13;
  localparam int TS_SQUELCH_LSB     = 9;
  localparam int TS_SQUELCH_W       = 4;
  localparam int TS_LINK_PULSE_BIT  = 7;
  localparam int TS_POLARITY_BIT    = 4;
  localparam int TS_JABBER_OFF_BIT  = 0;
  // --------------------------------------------------------------------
  // Pause advertisement bits inside an advertisement register [11:10]
  // --------------------------------------------------------------------
  localparam int ADV_PAUSE_BIT      = 0;
  localparam int ADV_ASYM_BIT       = 1;
  // Cycles after reset release before the synchronised straps are taken.
  localparam logic [1:0] STRAP_SETTLE_CYC = 2'h3;
endpackage : phyreg_pkg
`default_nettype wire

// *** phyreg_sync.sv ***
// Two flip-flop synchroniser for a group of pin levels.
`timescale 1ns/10ps
`default_nettype none
module phyreg_sync #(
  parameter int W = 1
) (
  input  wire logic         MCLK,
  input  wire logic         RESETN,
  input  wire logic [W-1:0] D,
  output var  logic [W-1:0] Q
);
  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      meta_q <= '0;
      Q      <= '0;
    end else begin
      meta_q <= D;
      Q      <= meta_q;
    end
  end
endmodule : phyreg_sync
`default_nettype wire

// *** pcsr_properties.sv ***
// Port-level checker for the transceiver register block.
`timescale 1ns/10ps
`default_nettype none
module pcsr_props (
  input wire logic        MCLK,
  input wire logic        RESETN,
  input wire logic [4:0]  REG_ADDR,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic [1:0]  LOCAL_PAUSE_ADV,
  input wire logic [1:0]  PARTNER_PAUSE_ADV,
  input wire logic        AN_COMPLETE,
  input wire logic        HCD_FULL_DUPLEX,
  input wire logic        LINK_UP,
  input wire logic        SPEED_100,
  input wire logic        POLARITY_INV_EVT,
  input wire logic        JABBER_OFF,
  input wire logic        PAUSE_RX_EN,
  input wire logic        PAUSE_TX_EN,
  input wire logic        AN_LINK100_FD,
  input wire logic        POLARITY_FLAG
);
  // Flags expected one cycle later, formed from this cycle's inputs.
  wire logic [1:0] l = LOCAL_PAUSE_ADV;
  wire logic [1:0] p = PARTNER_PAUSE_ADV;
  wire logic fd    = AN_COMPLETE & HCD_FULL_DUPLEX;
  wire logic rx_e  = fd & (l[0] & p[0] | l == 2'h3 & p == 2'h2);
  wire logic tx_e  = fd & (l[0] & p[0] | l == 2'h2 & p == 2'h3);
  wire logic lk_e  = fd & LINK_UP & SPEED_100;
  wire logic rd_ts = REG_RD & (REG_ADDR == 5'h1a);
  wire logic rd_xc = REG_RD & (REG_ADDR == 5'h19);
  wire logic rd_un = REG_RD & (REG_ADDR != 5'h19) & (REG_ADDR != 5'h1a);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  a_unmapped_reads_zero: assert property (
    rd_un |=> REG_RDATA == 16'h0000) else $error("unmapped read not zero");
  a_reserved_bits_zero: assert property (
    rd_ts |=> (REG_RDATA & 16'hc16e) == 16'h0000) else $error("reserved set");
  a_ctrl_reserved_zero: assert property (
    rd_xc |=> (REG_RDATA & 16'h0740) == 16'h0000)
    else $error("control reserved bit set");
  a_pause_rx_table: assert property (
    PAUSE_RX_EN == $past(rx_e)) else $error("pause receive flag wrong");
  a_pause_tx_table: assert property (
    PAUSE_TX_EN == $past(tx_e)) else $error("pause transmit flag wrong");
  a_pause_needs_fd: assert property (
    !$past(fd) |-> !PAUSE_RX_EN && !PAUSE_TX_EN) else $error("pause w/o fd");
  a_link100_flag: assert property (
    AN_LINK100_FD == $past(lk_e)) else $error("link flag wrong");
  a_polarity_set: assert property (
    POLARITY_INV_EVT |=> POLARITY_FLAG) else $error("polarity not set");
  a_polarity_read_clear: assert property (
    rd_ts && !POLARITY_INV_EVT |=> !POLARITY_FLAG) else $error("not cleared");
  a_jabber_ten_only: assert property (
    JABBER_OFF |-> !SPEED_100) else $error("jabber off at 100");
  c_polarity_read: cover property (rd_ts && POLARITY_FLAG);
  c_tx_pause_only: cover property (PAUSE_TX_EN && !PAUSE_RX_EN);
  c_link100: cover property (AN_LINK100_FD);
  c_polarity_set_on_read: cover property (rd_ts && POLARITY_INV_EVT);
endmodule : pcsr_props
`default_nettype wire

// *** pcsr_mgmt_model.sv ***
// Management controller model that issues single register cycles.
`timescale 1ns/10ps
`default_nettype none
module pcsr_mgmt (
  input  wire logic        MCLK,
  output var  logic [4:0]  REG_ADDR,
  output var  logic        REG_WR,
  output var  logic        REG_RD,
  output var  logic [15:0] REG_WDATA
);
  initial {REG_ADDR, REG_WR, REG_RD, REG_WDATA} = '0;
  // Address and data are inverted after a cycle and the strobes cleared, so a stale value never looks held.
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [15:0] d);
    @(negedge MCLK);
    {REG_ADDR, REG_WDATA, REG_WR, REG_RD} <= {a, d, w, !w};
    @(negedge MCLK);
    {REG_ADDR, REG_WDATA, REG_WR, REG_RD} <= {~a, ~d, 2'h0};
  endtask : xfer
endmodule : pcsr_mgmt
`default_nettype wire

// *** phy_control_10bt_status_regs_test.sv ***
// Self-checking bench for the transceiver control and status registers.
`timescale 1ns/10ps
`default_nettype none
module phy_control_10bt_status_regs_test;
  logic        mclk = 1'b0, rst_n = 1'b0, strap_x = 1'b1;
  logic [4:0]  strap_a = 5'h00;
  logic [1:0]  lpa = 2'h0, ppa = 2'h0;
  logic        an = 1'b0, hfd = 1'b0, lnk = 1'b0, s100 = 1'b0, pev = 1'b0;
  wire  logic [4:0]  addr, maddr;
  wire  logic [15:0] wdata, rdata;
  wire  logic [3:0]  sq;
  wire  logic        wr, rd, rvalid, axo, fxo, sbyp, icfg, lthr, lpo, jab;
  wire  logic        prx, ptx, l100, pflag;
  logic [15:0] exp_q[$];
  logic [15:0] wd, c19, c1a, xe;
  logic [2:0]  e;
  int          seed = 32'hcff9, num_errors = 0, checks_done = 0;
  pcsr_mgmt mgmt (.MCLK(mclk), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
    .REG_WDATA(wdata));
  phyreg_regs dut (.MCLK(mclk), .RESETN(rst_n), .REG_ADDR(addr),
    .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .STRAP_AUTO_XOVER(strap_x),
    .STRAP_MGMT_ADDR(strap_a), .LOCAL_PAUSE_ADV(lpa),
    .PARTNER_PAUSE_ADV(ppa), .AN_COMPLETE(an), .HCD_FULL_DUPLEX(hfd),
    .LINK_UP(lnk), .SPEED_100(s100), .POLARITY_INV_EVT(pev),
    .AUTO_XOVER_EN(axo), .FORCE_XOVER(fxo),
    .INDICATOR_STRETCH_BYPASS(sbyp), .INDICATOR_CONFIG(icfg),
    .LOWER_RX_THRESHOLD(lthr), .SQUELCH_SEL(sq), .LINK_PULSE_TX_OFF(lpo),
    .JABBER_OFF(jab), .PAUSE_RX_EN(prx), .PAUSE_TX_EN(ptx),
    .AN_LINK100_FD(l100), .POLARITY_FLAG(pflag), .MGMT_ADDR(maddr));
  initial forever #2 mclk = ~mclk;
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic rdx(input logic [4:0] a, input logic [15:0] x);
    exp_q.push_back(x);
    mgmt.xfer(1'b0, a, 16'h0000);
  endtask : rdx
  always @(negedge mclk) if (rvalid === 1'b1) cmp(rdata, exp_q.pop_front());
  task automatic end_sim;
    if (exp_q.size() != 0) num_errors++;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    #60000;
    num_errors++;
    end_sim();
  end
  initial begin
    strap_a = 5'($random(seed));
    strap_x = 1'($random(seed));
    repeat (12) @(negedge mclk);
    cmp(16'({axo, maddr}), 16'h0020);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    cmp(16'({axo, maddr}), 16'({strap_x, strap_a}));
    rdx(5'h19, {strap_x, 10'h000, strap_a});
    rdx(5'h1a, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wd = 16'($random(seed));
      mgmt.xfer(1'b1, 5'h19, wd);
      c19 = wd & 16'hc0a0;
      rdx(5'h19, c19 | 16'(strap_a));
      xe = 16'({wd[14], wd[15], wd[7], wd[5]});
      cmp(16'({fxo, axo, sbyp, icfg}), xe);
    end
    $display("test control done");
    for (int i = 0; i < 16; i++) begin
      wd = 16'($random(seed));
      {wd[12:9], wd[0]} = {4'(i), i[1]};
      s100 = i[0];
      mgmt.xfer(1'b1, 5'h1a, wd);
      c1a = wd & 16'h3e81;
      rdx(5'h1a, c1a);
      xe = 16'({wd[13:9], wd[7], wd[0] & !s100});
      cmp(16'({lthr, sq, lpo, jab}), xe);
    end
    $display("test ten_mbit done");
    for (int i = 0; i < 256; i++) begin
      {lpa, ppa, an, hfd, lnk, s100} = 8'(i);
      e[2] = an & hfd & (lpa[0] & ppa[0] | lpa == 2'h3 & ppa == 2'h2);
      e[1] = an & hfd & (lpa[0] & ppa[0] | lpa == 2'h2 & ppa == 2'h3);
      e[0] = an & hfd & lnk & s100;
      rdx(5'h19, c19 | 16'(strap_a) | {2'h0, e, 11'h000});
      cmp(16'({prx, ptx, l100}), 16'(e));
    end
    $display("test pause done");
    pev = 1'b1;
    @(negedge mclk);
    pev = 1'b0;
    cmp(16'(pflag), 16'h0001);
    rdx(5'h1a, c1a | 16'h0010);
    rdx(5'h1a, c1a);
    cmp(16'(pflag), 16'h0000);
    // A new event in the clearing read cycle must survive the clear.
    fork
      rdx(5'h1a, c1a);
      begin
        @(negedge mclk);
        pev = 1'b1;
        @(negedge mclk);
        pev = 1'b0;
      end
    join
    cmp(16'(pflag), 16'h0001);
    rdx(5'h1a, c1a | 16'h0010);
    $display("test polarity done");
    mgmt.xfer(1'b1, 5'h1b, 16'hffff);
    rdx(5'h1b, 16'h0000);
    rdx(5'h1a, c1a);
    repeat (3) @(negedge mclk);
    $display("test unmapped done");
    end_sim();
  end
endmodule : phy_control_10bt_status_regs_test
bind phyreg_regs pcsr_props u_props (.MCLK, .RESETN, .REG_ADDR, .REG_RD,
  .REG_RDATA, .LOCAL_PAUSE_ADV, .PARTNER_PAUSE_ADV, .AN_COMPLETE,
  .HCD_FULL_DUPLEX, .LINK_UP, .SPEED_100, .POLARITY_INV_EVT, .JABBER_OFF,
  .PAUSE_RX_EN, .PAUSE_TX_EN, .AN_LINK100_FD, .POLARITY_FLAG);
`default_nettype wire
